//--- core/pin_interrupt_inputs.sv
`timescale 1ns/1ps
`include "pin_irq_cfg.svh"

module pin_interrupt_inputs
  import pin_irq_pkg::*;
#(
  parameter int TIMER_W = `TIMER_WIDTH
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Pins
  input wire logic i_falling_edge_input_a,
  input wire logic i_falling_edge_input_b,
  input wire logic i_falling_edge_input_c,
  input wire logic i_rising_edge_input_a,
  input wire logic i_capture_pin,
  input wire logic i_p41_pin,
  input wire logic i_p40_pin,
  // Control
  input wire bus_ctrl_s i_bus_ctrl,
  input wire logic [1:0] i_capture_edge_sel,
  input wire logic [`EDGE_FLAG_WIDTH-1:0] i_interrupt_enable_register,
  input wire logic [`EDGE_FLAG_WIDTH-1:0] i_flag_clear,
  input wire logic i_cpu_irq_disable,
  input wire logic [TIMER_W-1:0] i_capture_timer_count,
  // Status and requests
  output logic [`EDGE_FLAG_WIDTH-1:0] o_interrupt_flag_register,
  output logic [TIMER_W-1:0] o_capture_timer_latch,
  output logic o_p41_gpio_in,
  output logic o_p40_gpio_in,
  output cpu_req_s o_cpu_req,
  output logic o_nmi_pulse
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_reg, sync1_next;
  logic [NPIN-1:0] sync2_reg, sync2_next;
  logic [NPIN-1:0] prev_reg, prev_next;
  logic [NPIN-1:0] fall_evt, rise_evt;

  assign pin_raw = {i_p40_pin, i_p41_pin, i_capture_pin, i_rising_edge_input_a,
                    i_falling_edge_input_c, i_falling_edge_input_b,
                    i_falling_edge_input_a};

  always_comb begin
    sync1_next = pin_raw;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_reg <= {NPIN{1'b1}};
      sync2_reg <= {NPIN{1'b1}};
      prev_reg <= {NPIN{1'b1}};
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
    end
  end

  // One-shot edge pulses
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_edge
      assign fall_evt[g] = prev_reg[g] & ~sync2_reg[g];
      assign rise_evt[g] = ~prev_reg[g] & sync2_reg[g];
    end
  endgenerate

  function automatic logic cap_hit(input logic [1:0] sel, input logic r, input logic f);
    unique case (sel)
      `CAP_SEL_OFF: cap_hit = 1'b0;
      `CAP_SEL_RISE: cap_hit = r;
      `CAP_SEL_FALL: cap_hit = f;
      `CAP_SEL_BOTH: cap_hit = r | f;
    endcase
  endfunction

  // ****************************************
  // Flags, capture and requests
  // ****************************************
  logic [`EDGE_FLAG_WIDTH-1:0] flag_reg, flag_next, set_vec;
  logic [TIMER_W-1:0] latch_reg, latch_next;
  logic cap_evt, level_low;
  cpu_req_s req_reg, req_next;
  logic nmi_reg, nmi_next;
  logic p41_reg, p41_next, p40_reg, p40_next;

  assign cap_evt = cap_hit(i_capture_edge_sel, rise_evt[4], fall_evt[4]);
  assign level_low = i_bus_ctrl.irq_select & ~sync2_reg[5];

  always_comb begin
    set_vec = '0;
    set_vec[`EDGE_FALL_A_BIT] = fall_evt[0];
    set_vec[`EDGE_FALL_B_BIT] = fall_evt[1];
    set_vec[`EDGE_FALL_C_BIT] = fall_evt[2];
    set_vec[`CAPTURE_FLAG_BIT] = cap_evt;
    set_vec[`EDGE_RISE_A_BIT] = rise_evt[3];
    flag_next = (flag_reg & ~i_flag_clear) | set_vec;
    flag_next[`LEVEL_FLAG_BIT] = level_low;
    latch_next = cap_evt ? i_capture_timer_count : latch_reg;
    req_next.maskable = ~i_cpu_irq_disable & |(flag_reg & i_interrupt_enable_register);
    req_next.nonmaskable = i_bus_ctrl.irq_select & fall_evt[6];
    req_next.abort = i_bus_ctrl.abort_enable & ~sync2_reg[6];
    nmi_next = req_next.nonmaskable;
    p41_next = i_bus_ctrl.irq_select ? 1'b1 : sync2_reg[5];
    p40_next = (i_bus_ctrl.irq_select | i_bus_ctrl.abort_enable) ? 1'b1 : sync2_reg[6];
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flag_reg <= `EDGE_FLAG_RESET;
      latch_reg <= TIMER_W'(`TIMER_RESET);
      req_reg <= '0;
      nmi_reg <= 1'b0;
      p41_reg <= 1'b1;
      p40_reg <= 1'b1;
    end else begin
      flag_reg <= flag_next;
      latch_reg <= latch_next;
      req_reg <= req_next;
      nmi_reg <= nmi_next;
      p41_reg <= p41_next;
      p40_reg <= p40_next;
    end
  end

  assign o_interrupt_flag_register = flag_reg;
  assign o_capture_timer_latch = latch_reg;
  assign o_cpu_req = req_reg;
  assign o_nmi_pulse = nmi_reg;
  assign o_p41_gpio_in = p41_reg;
  assign o_p40_gpio_in = p40_reg;

  // ****************************************
  // Assertions
  // ****************************************
  sequence fall_a_seq;
    prev_reg[0] && !sync2_reg[0];
  endsequence

  fall_sets_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    fall_a_seq |=> flag_reg[`EDGE_FALL_A_BIT]) else $error("falling edge lost");
  rise_no_set_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (rise_evt[0] && !flag_reg[0]) |=> !flag_reg[0]) else $error("rising edge set flag");
  mask_gate_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (|(flag_reg & i_interrupt_enable_register) && !i_cpu_irq_disable) |=> o_cpu_req.maskable)
    else $error("enabled flag not requested");
  disable_blocks_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    i_cpu_irq_disable |=> !o_cpu_req.maskable) else $error("request while disabled");
  level_flag_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_bus_ctrl.irq_select && !sync2_reg[5]) |=> flag_reg[`LEVEL_FLAG_BIT])
    else $error("level flag not set");
  level_hold_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (flag_reg[7] && i_interrupt_enable_register[7] && !i_cpu_irq_disable)[*2]
    |=> o_cpu_req.maskable) else $error("level request dropped");
  nmi_edge_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_bus_ctrl.irq_select && fall_evt[6]) |=> o_cpu_req.nonmaskable)
    else $error("nonmaskable edge lost");
  abort_en_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (!i_bus_ctrl.abort_enable) |=> !o_cpu_req.abort) else $error("abort while disabled");
  capture_flag_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    cap_evt |=> (flag_reg[3] && latch_reg == $past(i_capture_timer_count)))
    else $error("capture missing");
  sticky_flag_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (flag_reg[0] && !i_flag_clear[0]) |=> flag_reg[0]) else $error("flag dropped");

  sequence fall_b_seq;
    prev_reg[1] && !sync2_reg[1];
  endsequence

  sequence fall_c_seq;
    prev_reg[2] && !sync2_reg[2];
  endsequence

  sequence rise_a_seq;
    !prev_reg[3] && sync2_reg[3];
  endsequence

  sequence nmi_fall_seq;
    i_bus_ctrl.irq_select && prev_reg[6] && !sync2_reg[6];
  endsequence

  sequence level_low_seq;
    i_bus_ctrl.irq_select && !sync2_reg[5];
  endsequence

  sequence level_pair_seq;
    level_low_seq ##1 level_low_seq;
  endsequence

  fall_sets_b_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    fall_b_seq |=> flag_reg[`EDGE_FALL_B_BIT])
    else $error("falling edge b lost");

  fall_sets_c_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    fall_c_seq |=> flag_reg[`EDGE_FALL_C_BIT])
    else $error("falling edge c lost");

  rise_sets_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    rise_a_seq |=> flag_reg[`EDGE_RISE_A_BIT])
    else $error("rising edge lost");

  rise_pin_fall_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (fall_evt[3] && !flag_reg[`EDGE_RISE_A_BIT]) |=> !flag_reg[`EDGE_RISE_A_BIT])
    else $error("falling edge set rising flag");

  rise_no_set_b_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (rise_evt[1] && !flag_reg[1]) |=> !flag_reg[1])
    else $error("rising edge set flag b");

  nmi_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    nmi_fall_seq |=> o_nmi_pulse)
    else $error("nonmaskable pulse lost");

  nmi_single_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_cpu_req.nonmaskable |=> !o_cpu_req.nonmaskable)
    else $error("nonmaskable pulse too long");

  nmi_off_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !i_bus_ctrl.irq_select |=> !o_cpu_req.nonmaskable)
    else $error("nonmaskable while not selected");

  nmi_unmasked_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    nmi_fall_seq ##0 i_cpu_irq_disable |=> o_cpu_req.nonmaskable)
    else $error("nonmaskable blocked by disable");

  abort_follow_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_bus_ctrl.abort_enable && !sync2_reg[6]) |=> o_cpu_req.abort)
    else $error("abort request lost");

  both_funcs_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    nmi_fall_seq ##0 i_bus_ctrl.abort_enable |=> (o_cpu_req.nonmaskable && o_cpu_req.abort))
    else $error("shared pin functions not both active");

  p41_taken_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    i_bus_ctrl.irq_select |=> o_p41_gpio_in)
    else $error("gpio sees taken pin");

  p41_follow_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !i_bus_ctrl.irq_select |=> (o_p41_gpio_in == $past(sync2_reg[5])))
    else $error("gpio does not follow pin");

  level_clear_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !(i_bus_ctrl.irq_select && !sync2_reg[5]) |=> !flag_reg[`LEVEL_FLAG_BIT])
    else $error("level flag without low input");

  level_gate_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (flag_reg[7] && !i_interrupt_enable_register[7] &&
     ((flag_reg[6:0] & i_interrupt_enable_register[6:0]) == 7'h00)) |=> !o_cpu_req.maskable)
    else $error("level request while not enabled");

  level_req_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    level_pair_seq ##0 (i_interrupt_enable_register[7] && !i_cpu_irq_disable)
    |=> o_cpu_req.maskable) else $error("held level not requested");

  no_enable_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    ((flag_reg & i_interrupt_enable_register) == '0) |=> !o_cpu_req.maskable)
    else $error("request without enabled flag");

  capture_off_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_capture_edge_sel == `CAP_SEL_OFF) |=> $stable(o_capture_timer_latch))
    else $error("capture while off");

  capture_fall_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_capture_edge_sel == `CAP_SEL_FALL && prev_reg[4] && !sync2_reg[4])
    |=> (o_capture_timer_latch == $past(i_capture_timer_count)))
    else $error("falling capture lost");

  capture_rise_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_capture_edge_sel == `CAP_SEL_RISE && !prev_reg[4] && sync2_reg[4])
    |=> (o_capture_timer_latch == $past(i_capture_timer_count)))
    else $error("rising capture lost");

  capture_hold_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !cap_evt |=> $stable(latch_reg))
    else $error("latch moved without capture");

  flag_clear_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_flag_clear[0] && !fall_evt[0]) |=> !flag_reg[0])
    else $error("flag not cleared");

  set_wins_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (i_flag_clear[0] && fall_evt[0]) |=> flag_reg[0])
    else $error("clear beat a new edge");

  sticky_rise_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (flag_reg[4] && !i_flag_clear[4]) |=> flag_reg[4])
    else $error("rising flag dropped");

  sticky_capture_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (flag_reg[3] && !i_flag_clear[3]) |=> flag_reg[3])
    else $error("capture flag dropped");

endmodule

//--- core/pin_irq_cfg.svh
`ifndef PIN_IRQ_CFG_SVH
`define PIN_IRQ_CFG_SVH

// ****************************************
// Edge flag bit positions, widths and reset values
// ****************************************
`define EDGE_FALL_A_BIT 0
`define EDGE_FALL_B_BIT 1
`define EDGE_FALL_C_BIT 2
`define CAPTURE_FLAG_BIT 3
`define EDGE_RISE_A_BIT 4
`define LEVEL_FLAG_BIT 7
`define EDGE_FLAG_WIDTH 8
`define EDGE_FLAG_RESET 8'h00
`define TIMER_WIDTH 16
`define TIMER_RESET 16'h0000

// ****************************************
// Capture edge select codes
// ****************************************
`define CAP_SEL_OFF 2'h0
`define CAP_SEL_RISE 2'h1
`define CAP_SEL_FALL 2'h2
`define CAP_SEL_BOTH 2'h3

`endif

//--- core/pin_irq_pkg.sv
package pin_irq_pkg;

  typedef struct packed {
    logic irq_select;
    logic abort_enable;
  } bus_ctrl_s;

  typedef struct packed {
    logic maskable;
    logic nonmaskable;
    logic abort;
  } cpu_req_s;

  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b00,
    SYNC_RUN = 2'b01
  } sync_state_e;

endpackage

//--- tb/pin_source_model.sv
`timescale 1ns/1ps
// ****************************************
// External pin sources and registered timer count
// ****************************************
module pin_source_model (
  // Clock
  input wire logic i_mclk,
  // Requested levels
  input wire logic [6:0] i_level_req,
  input wire logic [15:0] i_count_req,
  // Pins and timer value
  output logic [6:0] o_pins = 7'h77,
  output logic [15:0] o_count = 16'h0000
);
  // Pins move on the edge and hold two or more cycles
  always @(posedge i_mclk) begin
    o_pins <= i_level_req;
    o_count <= i_count_req;
  end
endmodule

//--- tb/tb_pin_interrupt_inputs.sv
`timescale 1ns/1ps
module tb_pin_interrupt_inputs;
  import pin_irq_pkg::*;
  logic i_mclk = 0, i_arst_n = 0, irq_dis = 0, g41, g40, nmi;
  logic [6:0] lvl = 7'h77, pins;
  logic [15:0] cnt = 16'h0000, count, latch;
  logic [7:0] ien = 8'h00, clr = 8'h00, flags;
  logic [1:0] sel = 2'h0;
  bus_ctrl_s ctrl = '0;
  cpu_req_s req;
  int n_fail = 0, tests_run = 0, cyc = 0, nmi_seen = 0, nreq_seen = 0;
  pin_source_model pin_source_model_inst (.i_mclk(i_mclk), .i_level_req(lvl),
    .i_count_req(cnt), .o_pins(pins), .o_count(count));
  pin_interrupt_inputs pin_interrupt_inputs_inst (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_falling_edge_input_a(pins[0]), .i_falling_edge_input_b(pins[1]),
    .i_falling_edge_input_c(pins[2]), .i_rising_edge_input_a(pins[3]),
    .i_capture_pin(pins[4]), .i_p41_pin(pins[5]), .i_p40_pin(pins[6]),
    .i_bus_ctrl(ctrl), .i_capture_edge_sel(sel), .i_interrupt_enable_register(ien),
    .i_flag_clear(clr), .i_cpu_irq_disable(irq_dis), .i_capture_timer_count(count),
    .o_interrupt_flag_register(flags), .o_capture_timer_latch(latch),
    .o_p41_gpio_in(g41), .o_p40_gpio_in(g40), .o_cpu_req(req), .o_nmi_pulse(nmi));
  // ****************************************
  // Clock, pulse count and timeout
  // ****************************************
  initial begin
    forever #20 i_mclk = ~i_mclk;
  end
  always @(negedge i_mclk) begin
    cyc++;
    if (nmi === 1'b1) nmi_seen++;
    if (req.nonmaskable === 1'b1) nreq_seen++;
    if (cyc == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic pin(input int b, input logic v);
    lvl[b] = v;
    step(6);
  endtask
  task automatic clear(input logic [7:0] m);
    clr = m;
    step(1);
    clr = 8'h00;
    step(1);
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    step(5);
    i_arst_n = 1;
    step(2);
    chk(flags, 16'h0000, "flags after reset");
    chk(latch, 16'h0000, "latch after reset");
    chk({g41, g40}, 16'h0003, "gpio after reset");
    chk({req, nmi}, 16'h0000, "requests after reset");
    ien = 8'h01;
    pin(0, 0);
    chk(flags[0], 16'h0001, "fall a flag");
    chk(req.maskable, 16'h0001, "enabled request");
    irq_dis = 1;
    step(2);
    chk(req.maskable, 16'h0000, "masked request");
    irq_dis = 0;
    clear(8'h01);
    pin(0, 1);
    chk(flags[0], 16'h0000, "rise on fall pin");
    for (int b = 1; b < 3; b++) begin
      pin(b, 0);
      chk(flags[b], 16'h0001, "fall b c flag");
      pin(b, 1);
    end
    pin(3, 1);
    chk(flags[4], 16'h0001, "rise a flag");
    clear(8'h10);
    pin(3, 0);
    chk(flags[4], 16'h0000, "fall on rise pin");
    chk(flags[2:1], 16'h0003, "flags held");
    pin(5, 0);
    pin(6, 0);
    chk({g41, g40, flags[7], req.abort}, 16'h0000, "pins as gpio");
    chk(16'(nmi_seen + nreq_seen), 16'h0000, "no nmi when not selected");
    pin(5, 1);
    pin(6, 1);
    ctrl.irq_select = 1;
    ien = 8'h80;
    pin(5, 0);
    chk(flags[7], 16'h0001, "level flag");
    chk(req.maskable, 16'h0001, "level request");
    chk(g41, 16'h0001, "p41 taken");
    step(20);
    chk(req.maskable, 16'h0001, "level held");
    pin(5, 1);
    chk({flags[7], req.maskable}, 16'h0000, "level gone");
    irq_dis = 1;
    pin(6, 0);
    chk(16'(nmi_seen), 16'h0001, "nmi under disable");
    chk(16'(nreq_seen), 16'h0001, "nmi request pulse");
    pin(6, 1);
    ctrl.abort_enable = 1;
    pin(6, 0);
    chk(req.abort, 16'h0001, "abort request");
    chk(16'(nmi_seen), 16'h0002, "nmi with abort");
    chk(16'(nreq_seen), 16'h0002, "nmi request with abort");
    pin(6, 1);
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      cnt = 16'h1230 + 16'(s);
      clear(8'h08);
      pin(4, 0);
      chk(flags[3], {15'h0000, s[1]}, "capture on fall");
      pin(4, 1);
      chk(flags[3], {15'h0000, s[1] | s[0]}, "capture on rise");
      if (s != 0) chk(latch, cnt, "captured count");
      else chk(latch, 16'h0000, "no capture when off");
    end
    lvl[0] = 0;
    step(3);
    clear(8'h01);
    chk(flags[0], 16'h0001, "set beats clear");
    tally_and_finish();
  end
endmodule
